// File: logic/status_defs.svh
`ifndef STATUS_DEFS_SVH
`define STATUS_DEFS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define OFF_SRE      8'h00
`define OFF_ESE      8'h04
`define OFF_STB      8'h08
`define OFF_ESR      8'h0C
`define OFF_CMD      8'h10
`define OFF_ERRQ     8'h14
`define OFF_OUTQ     8'h18
`define OFF_ERRCNT   8'h1C
// ****************************************
// Command register bits
// ****************************************
`define CMD_CLS      0
`define CMD_OPC      1
`define CMD_OPCQ     2
`define CMD_SYSCLR   3
`define CMD_RST      4
// ****************************************
// Status byte and event bit positions
// ****************************************
`define STB_ERRQ     2
`define STB_QUES     3
`define STB_MAV      4
`define STB_ESB      5
`define STB_MSS      6
`define ESR_OPC      0
`define ESR_QYE      2
`define ESR_DDE      3
`define ESR_EXE      4
`define ESR_CME      5
`define ERRQ_VALID   16
`define OUTQ_VALID   8
// ****************************************
// Reset values and queue sizing
// ****************************************
`define MASK_RST     8'h00
`define ERRQ_DEPTH   10
`define OPC_RESP     8'h01
// ****************************************
// Error codes, 16-bit two's complement
// ****************************************
`define CODE_NONE    16'h0000
`define CODE_CMD     16'hFF9C
`define CODE_SYNTAX  16'hFF9A
`define CODE_UNDEF   16'hFF8F
`define CODE_RANGE   16'hFF23
`define CODE_TOOMUCH 16'hFF22
`define CODE_NOMEM   16'hFF20
`define CODE_UNTERM  16'hFE66
`define CODE_DEADLK  16'hFE5C
`define CODE_INDEF   16'hFE48
`define CODE_QOVF    16'hFEB6
`define CODE_RDOVF   16'h012D
`define CODE_PTMO    16'h012E
`define CODE_BUFFULL 16'h0136
`define CODE_CLEVT   16'h0140
`define CODE_CLTRIP  16'h0141
`define CODE_OTP     16'h0199
`define CODE_OVP     16'h019A
`endif

// File: logic/status_pkg.sv
package status_pkg;
  // Error sources reported by the rest of the instrument
  typedef enum logic [3:0] {
    ERR_CMD, ERR_SYNTAX, ERR_UNDEF_HDR, ERR_RANGE, ERR_TOO_MUCH, ERR_NO_MEM,
    ERR_UNTERM, ERR_DEADLOCK, ERR_INDEF, ERR_RD_OVF, ERR_PULSE_TMO, ERR_BUF_FULL,
    ERR_CLIM_EVT, ERR_CLIM_TRIP, ERR_OVER_TEMP, ERR_OVER_VOLTAGE
  } err_kind_e;
  // Operation complete tracking, one-hot
  typedef enum logic [2:0] {
    OPC_IDLE  = 3'b001,
    OPC_WSET  = 3'b010,
    OPC_WRESP = 3'b100
  } opc_state_e;
endpackage : status_pkg

// File: logic/err_mem_if.sv
`timescale 1ns/10ps
`default_nettype none
interface err_mem_if #(parameter int AW = 4);
  logic          we;
  logic [AW-1:0] waddr;
  logic [15:0]   wdata;
  logic [AW-1:0] raddr;
  logic [15:0]   rdata;
  modport ctrl (output we, waddr, wdata, raddr, input rdata);
  modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface : err_mem_if
`default_nettype wire

// File: logic/err_mem.sv
`timescale 1ns/10ps
`default_nettype none
module err_mem #(
  parameter int DEPTH = 10,
  parameter int AW    = 4
) (
  input wire logic clk,
  err_mem_if.mem   port
);
  // ****************************************
  // Storage with registered read and write bypass
  // ****************************************
  logic [15:0] mem_reg [DEPTH];
  logic [15:0] rdata_reg;
  wire         bypass = port.we && (port.waddr == port.raddr);

  always_ff @(posedge clk) begin
    if (port.we) begin
      mem_reg[port.waddr] <= port.wdata;
    end
    rdata_reg <= bypass ? port.wdata : mem_reg[port.raddr];
  end

  assign port.rdata = rdata_reg;
endmodule : err_mem
`default_nettype wire

// File: logic/status_error_queue.sv
`timescale 1ns/10ps
`default_nettype none
`include "status_defs.svh"
// How it works
// - Service request mask written, bits enable summary
// - Mask query returns mask, unchanged
// - Status byte read never clears bit 6
// - Standard event mask written from bus
// - Event mask query returns enabled bits
// - Event register query returns latched bits
// - Clear-status clears event register and its summary, cancels operation complete
// - Operation-complete sets bit after pending work
// - Operation-complete query queues response one
// - Error queue returns oldest entry first
// - Reading an error removes it
// - Eleventh error replaces last slot, locks queue
// - Empty queue read returns code zero
// - System clear or power-on empties queue
// - Instrument reset leaves error queue alone
// - Command errors queue -100, -102, -113
// - Parameter errors queue -221, -222, -224
// - Query errors queue -410, -420, -440
// - Measurement conditions queue +301, +302, +310
// - Protection conditions queue +320, +321, +409, +410
// - Event register read or clear-status clears
// - Status bit 2 set while errors stored
// - Event bit 0 set only by operation-complete
// - Events latch and summarise only when enabled
module status_error_queue #(
  parameter int DEPTH = `ERRQ_DEPTH,
  parameter int AW    = 4
) (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                err_strobe,
  input  wire status_pkg::err_kind_e err_kind,
  input  wire logic                ops_busy,
  input  wire logic                questionable_summary,
  output logic                     service_request
);
  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_inc

  function automatic logic [AW-1:0] ptr_dec(input logic [AW-1:0] p);
    ptr_dec = (p == '0) ? AW'(DEPTH - 1) : AW'(p - 1'b1);
  endfunction : ptr_dec

  function automatic logic [15:0] err_code(input status_pkg::err_kind_e k);
    case (k)
      status_pkg::ERR_CMD:          err_code = `CODE_CMD;
      status_pkg::ERR_SYNTAX:       err_code = `CODE_SYNTAX;
      status_pkg::ERR_UNDEF_HDR:    err_code = `CODE_UNDEF;
      status_pkg::ERR_RANGE:        err_code = `CODE_RANGE;
      status_pkg::ERR_TOO_MUCH:     err_code = `CODE_TOOMUCH;
      status_pkg::ERR_NO_MEM:       err_code = `CODE_NOMEM;
      status_pkg::ERR_UNTERM:       err_code = `CODE_UNTERM;
      status_pkg::ERR_DEADLOCK:     err_code = `CODE_DEADLK;
      status_pkg::ERR_INDEF:        err_code = `CODE_INDEF;
      status_pkg::ERR_RD_OVF:       err_code = `CODE_RDOVF;
      status_pkg::ERR_PULSE_TMO:    err_code = `CODE_PTMO;
      status_pkg::ERR_BUF_FULL:     err_code = `CODE_BUFFULL;
      status_pkg::ERR_CLIM_EVT:     err_code = `CODE_CLEVT;
      status_pkg::ERR_CLIM_TRIP:    err_code = `CODE_CLTRIP;
      status_pkg::ERR_OVER_TEMP:    err_code = `CODE_OTP;
      default:                      err_code = `CODE_OVP;
    endcase
  endfunction : err_code

  // ****************************************
  // State
  // ****************************************
  logic [7:0]             service_request_mask_reg;
  logic [7:0]             std_event_mask_reg;
  logic [7:0]             esr_reg;
  logic [7:0]             esr_next;
  logic                   outq_reg;
  logic                   outq_next;
  logic [AW-1:0]          wr_ptr_reg;
  logic [AW-1:0]          rd_ptr_reg;
  logic [AW-1:0]          rd_ptr_next;
  logic [AW:0]            count_reg;
  logic [AW:0]            count_next;
  logic                   locked_reg;
  status_pkg::opc_state_e opc_reg;
  status_pkg::opc_state_e opc_next;
  err_mem_if #(.AW(AW))   mif ();

  err_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk  (clk),
    .port (mif)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  wire bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr   = bus_req && wb_we_i && wb_sel_i[0];
  wire bus_rd   = bus_req && !wb_we_i;
  wire hit_sre  = (wb_adr_i == `OFF_SRE);
  wire hit_ese  = (wb_adr_i == `OFF_ESE);
  wire hit_stb  = (wb_adr_i == `OFF_STB);
  wire hit_esr  = (wb_adr_i == `OFF_ESR);
  wire hit_cmd  = (wb_adr_i == `OFF_CMD);
  wire hit_errq = (wb_adr_i == `OFF_ERRQ);
  wire hit_outq = (wb_adr_i == `OFF_OUTQ);
  wire hit_cnt  = (wb_adr_i == `OFF_ERRCNT);
  wire [7:0] cmd = (bus_wr && hit_cmd) ? wb_dat_i[7:0] : 8'h00;
  wire do_cls    = cmd[`CMD_CLS];
  wire do_opc    = cmd[`CMD_OPC];
  wire do_opcq   = cmd[`CMD_OPCQ];
  wire do_sysclr = cmd[`CMD_SYSCLR];
  wire do_rst    = cmd[`CMD_RST];

  // ****************************************
  // Error queue control
  // ****************************************
  wire q_empty   = (count_reg == '0);
  wire q_full    = (count_reg == (AW+1)'(DEPTH));
  wire pop       = bus_rd && hit_errq && !q_empty;
  wire empty_rd  = bus_rd && hit_errq && q_empty;
  wire push      = err_strobe && !locked_reg && !do_sysclr;
  wire push_ovf  = push && q_full && !pop;
  wire push_norm = push && !push_ovf;
  wire [15:0] push_code = err_code(err_kind);

  assign mif.we    = push;
  assign mif.waddr = push_ovf ? ptr_dec(wr_ptr_reg) : wr_ptr_reg;
  assign mif.wdata = push_ovf ? `CODE_QOVF : push_code;
  assign rd_ptr_next = do_sysclr ? '0 : (pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg);
  assign mif.raddr = rd_ptr_next;

  always_comb begin
    count_next = count_reg;
    if (do_sysclr) begin
      count_next = '0;
    end else if (push_norm && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push_norm) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || do_sysclr) begin
      wr_ptr_reg <= '0;
      locked_reg <= 1'b0;
    end else begin
      if (push_norm) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (push_ovf) begin
        locked_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // ****************************************
  // Standard events and operation complete
  // ****************************************
  wire k_cmd  = (err_kind <= status_pkg::ERR_UNDEF_HDR);
  wire k_exe  = (err_kind >= status_pkg::ERR_RANGE) && (err_kind <= status_pkg::ERR_NO_MEM);
  wire k_qye  = (err_kind >= status_pkg::ERR_UNTERM) && (err_kind <= status_pkg::ERR_INDEF);
  wire opc_fire = (opc_reg == status_pkg::OPC_WSET) && !ops_busy;
  wire [7:0] ev_raw = {2'b00,
                       err_strobe && k_cmd,
                       err_strobe && k_exe,
                       err_strobe && !k_cmd && !k_exe && !k_qye,
                       (err_strobe && k_qye) || empty_rd,
                       1'b0,
                       opc_fire};
  wire [7:0] ev_en  = ev_raw & std_event_mask_reg;
  wire esr_clr      = do_cls || (bus_rd && hit_esr);
  assign esr_next   = (esr_clr ? 8'h00 : esr_reg) | ev_en;

  always_comb begin
    opc_next = opc_reg;
    case (opc_reg)
      status_pkg::OPC_IDLE: begin
        if (do_opcq) begin
          opc_next = status_pkg::OPC_WRESP;
        end else if (do_opc) begin
          opc_next = status_pkg::OPC_WSET;
        end
      end
      status_pkg::OPC_WSET: begin
        if (!ops_busy) begin
          opc_next = status_pkg::OPC_IDLE;
        end
      end
      status_pkg::OPC_WRESP: begin
        if (!ops_busy) begin
          opc_next = status_pkg::OPC_IDLE;
        end
      end
      default: opc_next = status_pkg::OPC_IDLE;
    endcase
    if (do_cls || do_rst) begin
      opc_next = status_pkg::OPC_IDLE;
    end
  end

  wire resp_fire = (opc_reg == status_pkg::OPC_WRESP) && !ops_busy;
  assign outq_next = resp_fire || (outq_reg && !(bus_rd && hit_outq));

  always_ff @(posedge clk) begin
    if (!resetn) begin
      esr_reg  <= `MASK_RST;
      opc_reg  <= status_pkg::OPC_IDLE;
      outq_reg <= 1'b0;
    end else begin
      esr_reg  <= esr_next;
      opc_reg  <= opc_next;
      outq_reg <= outq_next;
    end
  end

  // ****************************************
  // Enable masks
  // ****************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      service_request_mask_reg <= `MASK_RST;
      std_event_mask_reg       <= `MASK_RST;
    end else begin
      if (bus_wr && hit_sre) begin
        service_request_mask_reg <= wb_dat_i[7:0];
      end
      if (bus_wr && hit_ese) begin
        std_event_mask_reg <= wb_dat_i[7:0];
      end
    end
  end

  // ****************************************
  // Status byte
  // ****************************************
  wire [7:0] stb_low;
  assign stb_low[1:0]      = 2'b00;
  assign stb_low[`STB_ERRQ] = !q_empty;
  assign stb_low[`STB_QUES] = questionable_summary;
  assign stb_low[`STB_MAV]  = outq_reg;
  assign stb_low[`STB_ESB]  = |(esr_reg & std_event_mask_reg);
  assign stb_low[7:6]      = 2'b00;
  wire master_summary_flag = |(stb_low & service_request_mask_reg);
  wire [7:0] status_byte   = stb_low | (8'(master_summary_flag) << `STB_MSS);

  // ****************************************
  // Read mux and bus answer
  // ****************************************
  wire [31:0] rd_errq = q_empty ? 32'h0000_0000 :
                        {15'h0, 1'b1, mif.rdata};
  wire [31:0] rd_data =
      hit_sre  ? {24'h000000, service_request_mask_reg} :
      hit_ese  ? {24'h000000, std_event_mask_reg} :
      hit_stb  ? {24'h000000, status_byte} :
      hit_esr  ? {24'h000000, esr_reg} :
      hit_errq ? rd_errq :
      hit_outq ? {23'h0, outq_reg, (outq_reg ? `OPC_RESP : 8'h00)} :
      hit_cnt  ? {{(30-AW){1'b0}}, locked_reg, count_reg} :
                 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wb_ack_o        <= 1'b0;
      wb_dat_o        <= 32'h0000_0000;
      service_request <= 1'b0;
    end else begin
      wb_ack_o        <= bus_req;
      wb_dat_o        <= bus_rd ? rd_data : 32'h0000_0000;
      service_request <= master_summary_flag;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_sre_holds: assert property (!(bus_wr && hit_sre) |=> $stable(service_request_mask_reg))
    else $error("service request mask changed without write");
  a_stb_read_keeps: assert property (bus_rd && hit_stb && master_summary_flag && !bus_wr
      && $stable(esr_reg) |=> wb_dat_o[`STB_MSS])
    else $error("status byte read lost master summary");
  a_esr_read_clr: assert property (bus_rd && hit_esr && ev_en == 8'h00 |=> esr_reg == 8'h00)
    else $error("event register not cleared by read");
  a_opc_sets_bit: assert property (opc_fire && std_event_mask_reg[`ESR_OPC] |=> esr_reg[`ESR_OPC])
    else $error("operation complete bit not set");
  a_opcq_resp: assert property (resp_fire |=> outq_reg)
    else $error("operation complete response missing");
  a_queue_lock: assert property (push_ovf |=> locked_reg && count_reg == $past(count_reg))
    else $error("overflow did not lock queue");
  a_empty_zero: assert property (empty_rd |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("empty queue read not zero");
  a_sysclr_empty: assert property (do_sysclr |=> q_empty && !locked_reg ##1 !locked_reg || push)
    else $error("system clear left entries");
  a_rst_keeps_q: assert property (do_rst && !do_sysclr && !pop && !push |=> $stable(count_reg))
    else $error("instrument reset changed queue");
  a_err_flag: assert property (bus_rd && hit_stb |=> wb_dat_o[`STB_ERRQ] == ($past(count_reg) != '0))
    else $error("error queue bit wrong");
  a_count_bound: assert property (count_reg <= (AW+1)'(DEPTH))
    else $error("queue count beyond depth");
  a_srq_follows: assert property (service_request == $past(master_summary_flag))
    else $error("service request not following summary");
  a_esr_enabled: assert property ((esr_reg & ~$past(esr_reg) & ~$past(std_event_mask_reg)) == 8'h00)
    else $error("disabled event bit latched");
  a_opc_only: assert property ($rose(esr_reg[`ESR_OPC]) |-> $past(opc_fire))
    else $error("operation complete bit set without command");
  a_outq_clear: assert property (bus_rd && hit_outq && !resp_fire |=> !outq_reg)
    else $error("output queue read did not clear");

  c_overflow: cover property (push_ovf);
  c_opc_done: cover property (opc_fire);
  c_opcq_resp: cover property (resp_fire);
  c_srq_raised: cover property (master_summary_flag ##1 service_request);
  c_pop_entry: cover property (pop ##1 wb_ack_o);
endmodule : status_error_queue
`default_nettype wire

// File: test/op_source.sv
`timescale 1ns/10ps
`default_nettype none
module op_source (
  input  wire logic                  clk,
  output var  logic                  err_strobe,
  output var  status_pkg::err_kind_e err_kind,
  output var  logic                  ops_busy
);
  // ****************************************
  // Instrument side: error reports and pending work
  // ****************************************
  initial begin
    err_strobe = 1'b0;
    err_kind   = status_pkg::ERR_CMD;
    ops_busy   = 1'b0;
  end

  // One-cycle error report, kind scrambled once the strobe is gone
  task automatic raise(input int k);
    err_kind   <= status_pkg::err_kind_e'(k);
    err_strobe <= 1'b1;
    @(posedge clk);
    err_strobe <= 1'b0;
    err_kind   <= status_pkg::err_kind_e'(k ^ 15);
    @(posedge clk);
  endtask : raise

  // Operation pending for n cycles
  task automatic work(input int n);
    ops_busy <= 1'b1;
    repeat (n) @(posedge clk);
    ops_busy <= 1'b0;
  endtask : work
endmodule : op_source
`default_nettype wire

// File: test/tb_status_error_queue.sv
`timescale 1ns/10ps
`default_nettype none
`include "status_defs.svh"
module tb_status_error_queue;
  // ****************************************
  // Signals and tables
  // ****************************************
  logic                  clk, resetn, cyc, stb, we, q_sum, ack, sreq, e_stb, busy;
  logic [7:0]            adr, v;
  logic [3:0]            sel;
  logic [31:0]           dat_i, dat_o;
  status_pkg::err_kind_e kind;
  int                    errors, n_compared;
  logic [31:0]           exp_q[$];
  int codes[16] = '{-100, -102, -113, -221, -222, -224, -410, -420, -440, 301, 302, 310, 320, 321, 409, 410};
  int rep[4] = '{0, 3, 6, 9};
  logic [7:0] rbit[4] = '{8'h20, 8'h10, 8'h04, 8'h08};
  logic [7:0] offs[8] = '{`OFF_SRE, `OFF_ESE, `OFF_STB, `OFF_ESR, `OFF_ERRQ, `OFF_OUTQ, `OFF_ERRCNT, 8'h20};

  status_error_queue DUT (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .err_strobe(e_stb), .err_kind(kind), .ops_busy(busy), .questionable_summary(q_sum),
    .service_request(sreq));
  op_source SRC (.clk(clk), .err_strobe(e_stb), .err_kind(kind), .ops_busy(busy));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", what, e, g);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_i <= d;
    sel   <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 32'h1, 32'h0);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, $urandom, 4'($urandom));
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d}, 4'h1);
  endtask : wr

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // ****************************************
  // Clock, monitor, watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) chk($sformatf("read %h", adr), exp_q.pop_front(), dat_o);
  end

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    close_out();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {resetn, cyc, stb, we, q_sum, adr, sel, dat_i} = '0;
    void'($urandom(32'h1969));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (offs[i]) rd(offs[i], 32'h0);
    rd(`OFF_ERRQ, 32'h0);
    v = 8'($urandom);
    q_sum <= v[0];
    rd(`OFF_STB, {28'h0, v[0], 3'h0});
    q_sum <= ~v[0];
    rd(`OFF_STB, {28'h0, ~v[0], 3'h0});
    q_sum <= 1'b0;
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      wr(`OFF_SRE, v);
      wr(`OFF_ESE, ~v);
      rd(`OFF_SRE, {24'h0, v});
      rd(`OFF_SRE, {24'h0, v});
      rd(`OFF_ESE, {24'h0, ~v});
    end
    bus(1'b1, `OFF_SRE, 32'h00, 4'hE);
    rd(`OFF_SRE, {24'h0, v});
    wr(8'h20, 8'hFF);
    rd(8'h20, 32'h0);
    wr(`OFF_SRE, 8'h00);
    wr(`OFF_ESE, 8'h00);
    $display("test masks done");
    for (int k = 0; k < 16; k++) begin
      SRC.raise(k);
      rd(`OFF_STB, 32'h04);
      rd(`OFF_ERRQ, {15'h0, 1'b1, 16'(codes[k])});
      rd(`OFF_STB, 32'h00);
    end
    $display("test codes done");
    wr(`OFF_ESE, 8'h3D);
    foreach (rep[i]) begin
      SRC.raise(rep[i]);
      rd(`OFF_STB, 32'h24);
      rd(`OFF_ESR, {24'h0, rbit[i]});
      rd(`OFF_ESR, 32'h0);
      rd(`OFF_ERRQ, {15'h0, 1'b1, 16'(codes[rep[i]])});
    end
    rd(`OFF_ERRQ, 32'h0);
    rd(`OFF_ESR, 32'h04);
    wr(`OFF_SRE, 8'h04);
    SRC.raise(3);
    rd(`OFF_STB, 32'h64);
    rd(`OFF_STB, 32'h64);
    chk("service request", 32'h1, {31'h0, sreq});
    wr(`OFF_CMD, 8'h01);
    rd(`OFF_ESR, 32'h0);
    rd(`OFF_ESE, 32'h3D);
    wr(`OFF_SRE, 8'h00);
    wr(`OFF_ESE, 8'h00);
    SRC.raise(0);
    rd(`OFF_ESR, 32'h0);
    wr(`OFF_CMD, 8'h08);
    chk("service request", 32'h0, {31'h0, sreq});
    $display("test events done");
    for (int k = 0; k < 12; k++) SRC.raise(k);
    rd(`OFF_ERRCNT, 32'h2A);
    wr(`OFF_CMD, 8'h10);
    rd(`OFF_ERRCNT, 32'h2A);
    for (int k = 0; k < 9; k++) rd(`OFF_ERRQ, {15'h0, 1'b1, 16'(codes[k])});
    rd(`OFF_ERRQ, {15'h0, 1'b1, 16'hFEB6});
    rd(`OFF_ERRQ, 32'h0);
    SRC.raise(1);
    rd(`OFF_ERRQ, 32'h0);
    wr(`OFF_CMD, 8'h08);
    SRC.raise(2);
    rd(`OFF_ERRCNT, 32'h01);
    wr(`OFF_CMD, 8'h08);
    rd(`OFF_ERRCNT, 32'h00);
    SRC.raise(4);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(`OFF_ERRCNT, 32'h00);
    $display("test queue done");
    wr(`OFF_ESE, 8'h01);
    fork SRC.work(20); join_none
    wr(`OFF_CMD, 8'h02);
    rd(`OFF_ESR, 32'h0);
    while (busy) @(posedge clk);
    rd(`OFF_ESR, 32'h01);
    fork SRC.work(20); join_none
    wr(`OFF_CMD, 8'h04);
    rd(`OFF_OUTQ, 32'h0);
    while (busy) @(posedge clk);
    rd(`OFF_STB, 32'h10);
    rd(`OFF_OUTQ, 32'h101);
    rd(`OFF_OUTQ, 32'h0);
    $display("test completion done");
    close_out();
  end
endmodule : tb_status_error_queue
`default_nettype wire
